// File: verilog/dsvs_pkg.sv
// shared constants, types and helper functions of the video sequencer
package dsvs_pkg;

  // ----------------------------------------
  // link and packet geometry
  // ----------------------------------------
  localparam int MAX_LANES = 4;
  localparam int BYTES_PER_PIXEL = 3;
  localparam int HDR_BYTES = 4; // a short packet is a bare header
  localparam int CRC_BYTES = 2;
  localparam logic [1:0] VC_ID = 2'h0;

  // ----------------------------------------
  // packet data types
  // ----------------------------------------
  localparam logic [5:0] DT_VSS = 6'h01;
  localparam logic [5:0] DT_VSE = 6'h11;
  localparam logic [5:0] DT_HSS = 6'h21;
  localparam logic [5:0] DT_HSE = 6'h31;
  localparam logic [5:0] DT_EOTP = 6'h08;
  localparam logic [5:0] DT_BLANK = 6'h19;
  localparam logic [5:0] DT_NULL = 6'h09;
  localparam logic [5:0] DT_RGB888 = 6'h3e;
  localparam logic [15:0] EOTP_WORD = 16'h0f0f;
  localparam logic [15:0] SHORT_WORD = 16'h0000;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // ----------------------------------------
  // checksum and header code
  // ----------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_OFF = 16'h0000;
  localparam int ECC_BITS = 6;
  localparam logic [5:0][23:0] ECC_MASK = {24'heffc00, 24'hdf03f0, 24'hb8e38e,
                                           24'h749a6d, 24'hf2555b, 24'hf12cb7};

  // ----------------------------------------
  // status bits
  // ----------------------------------------
  localparam int ISR_UNDERRUN = 0;
  localparam int ISR_FRAME = 1;
  localparam int ISR_W = 2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] hsa;
    logic [15:0] hbp;
    logic [15:0] hact;
    logic [15:0] hfp;
    logic [15:0] vact;
    logic [7:0] vsa;
    logic [7:0] vbp;
    logic [7:0] vfp;
    logic events_mode;
    logic eotp;
  } dsvs_cfg_t;

  typedef enum logic [2:0] {SEG_SS, SEG_SA, SEG_SE, SEG_BP, SEG_ACT, SEG_FP, SEG_EOT} dsvs_seg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_CRC} dsvs_st_t;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // header error code over the three header bytes
  function automatic logic [7:0] dsvs_ecc(input logic [23:0] d);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < ECC_BITS; i++) begin
      e[i] = ^(d & ECC_MASK[i]);
    end
    return e;
  endfunction

  // payload checksum, one byte, lsb first
  function automatic logic [15:0] dsvs_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// File: verilog/dsvs_cfg_if.sv
// timing set crossing from the register clock to the link clock
`timescale 1ns/1ps
interface dsvs_cfg_if #(
  parameter int W = $bits(dsvs_pkg::dsvs_cfg_t)
);
  logic [W-1:0] src_word;
  logic src_take;
  logic [W-1:0] dst_word;
  logic dst_load;

  modport src (output src_word, input src_take);
  modport dst (input dst_word, input dst_load);
  modport cdc (input src_word, output src_take, output dst_word, output dst_load);
endinterface

// File: verilog/dsvs_cfg_cdc.sv
// toggle handshake that moves a whole timing word between two clocks
`timescale 1ns/1ps
module dsvs_cfg_cdc #(
  parameter int W = $bits(dsvs_pkg::dsvs_cfg_t)
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic dst_clk,
  input wire logic dst_rst,
  dsvs_cfg_if.cdc bus
);

  logic [W-1:0] hold_reg, hold_next;
  logic req_reg, req_next;
  logic ack_s1_reg, ack_s2_reg;
  logic req_s1_reg, req_s2_reg;
  logic seen_reg, seen_next;
  logic [W-1:0] word_reg, word_next;
  logic load_reg, load_next;
  logic idle;

  // source side: capture a fresh word once the last one was taken
  always_comb begin
    idle = (ack_s2_reg == req_reg);
    hold_next = idle ? bus.src_word : hold_reg;
    req_next = idle ? ~req_reg : req_reg;
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      hold_reg <= '0;
      req_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      req_reg <= req_next;
      ack_s1_reg <= seen_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign bus.src_take = idle;

  // destination side: hold word is stable while the request toggle is seen
  always_comb begin
    seen_next = req_s2_reg;
    load_next = (req_s2_reg != seen_reg);
    word_next = load_next ? hold_reg : word_reg;
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      seen_reg <= 1'b0;
      word_reg <= '0;
      load_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      seen_reg <= seen_next;
      word_reg <= word_next;
      load_reg <= load_next;
    end
  end

  assign bus.dst_word = word_reg;
  assign bus.dst_load = load_reg;

endmodule

// File: verilog/dsvs_sequencer.sv
// video line framer: wraps the pixel stream in sync, blanking and pixel packets
`timescale 1ns/1ps
module dsvs_sequencer #(
  parameter int LANES = 4,
  parameter int PIXELS = 1,
  parameter bit CRC_GEN = 1'b1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic core_enable,
  input wire logic events_mode,
  input wire logic eotp_enable,
  input wire logic blank_null,
  input wire logic [15:0] hsa_wc,
  input wire logic [15:0] hbp_wc,
  input wire logic [15:0] hact_wc,
  input wire logic [15:0] hfp_wc,
  input wire logic [15:0] vact_lines,
  input wire logic [7:0] vsa_lines,
  input wire logic [7:0] vbp_lines,
  input wire logic [7:0] vfp_lines,
  input wire logic soft_reset,
  input wire logic [dsvs_pkg::ISR_W-1:0] isr_clear,
  input wire logic [dsvs_pkg::ISR_W-1:0] irq_mask,
  input wire logic irq_enable,
  output logic core_ready,
  output logic [dsvs_pkg::ISR_W-1:0] interrupt_status_reg,
  output logic irq,
  output logic ctrl_rst_n,
  output logic phy_core_rst,
  input wire logic [PIXELS*dsvs_pkg::BYTES_PER_PIXEL*8-1:0] s_axis_tdata,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  output logic [7:0] link_byte,
  output logic link_valid,
  output logic [1:0] link_lane
);

  // ----------------------------------------
  // sizing
  // ----------------------------------------
  localparam int LANES_USED = (LANES > dsvs_pkg::MAX_LANES) ? dsvs_pkg::MAX_LANES : LANES;
  localparam int BEAT_BYTES = PIXELS * dsvs_pkg::BYTES_PER_PIXEL;
  localparam int BEAT_W = $clog2(BEAT_BYTES);
  localparam logic [1:0] LANE_LAST = 2'(LANES_USED - 1);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(BEAT_BYTES - 1);
  localparam logic [15:0] HDR_LAST = 16'(dsvs_pkg::HDR_BYTES - 1);
  localparam logic [15:0] CRC_LAST = 16'(dsvs_pkg::CRC_BYTES - 1);

  // ----------------------------------------
  // resets
  // ----------------------------------------
  // phy takes the reset active high, controller side active low
  assign phy_core_rst = sys_rst;
  assign ctrl_rst_n = ~sys_rst;

  // link domain reset: asserts at once, releases on the link clock
  logic lrst_s1_reg, link_rst;
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_s1_reg <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      lrst_s1_reg <= 1'b0;
      link_rst <= lrst_s1_reg;
    end
  end

  // ----------------------------------------
  // timing set crossing
  // ----------------------------------------
  dsvs_pkg::dsvs_cfg_t cfg_in, shadow, cur_reg, cur_next;
  dsvs_cfg_if cfg_bus ();

  // register-clock side of the settings, packed in field order and sent over continuously
  assign cfg_in = {hsa_wc, hbp_wc, hact_wc, hfp_wc, vact_lines, vsa_lines, vbp_lines,
                   vfp_lines, events_mode, eotp_enable};

  assign cfg_bus.src_word = cfg_in;
  assign shadow = cfg_bus.dst_word;

  dsvs_cfg_cdc u_cfg_cdc (
    .src_clk (clk_sys),
    .src_rst (sys_rst),
    .dst_clk (link_clk),
    .dst_rst (link_rst),
    .bus (cfg_bus.cdc)
  );

  // ----------------------------------------
  // level synchronisers into the link domain
  // ----------------------------------------
  logic en_s1_reg, en_s2_reg, bn_s1_reg, bn_s2_reg;
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      bn_s1_reg <= 1'b0;
      bn_s2_reg <= 1'b0;
    end else begin
      en_s1_reg <= core_enable;
      en_s2_reg <= en_s1_reg;
      bn_s1_reg <= blank_null;
      bn_s2_reg <= bn_s1_reg;
    end
  end

  // ----------------------------------------
  // framer state
  // ----------------------------------------
  dsvs_pkg::dsvs_st_t st_reg, st_next;
  dsvs_pkg::dsvs_seg_t seg_reg, seg_next, seg_adv;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] line_reg, line_next;
  logic [15:0] crc_reg, crc_next;
  logic [1:0] lane_reg, lane_next;
  logic [BEAT_W-1:0] beat_reg, beat_next;
  logic shadow_ok_reg, shadow_ok_next;
  logic [5:0] blank_dt_reg, blank_dt_next;
  logic [7:0] byte_reg, byte_next;
  logic valid_reg, valid_next;
  logic urun_tgl_reg, urun_tgl_next;
  logic frm_tgl_reg, frm_tgl_next;
  logic [7:0] byte_now;
  logic [5:0] dt;
  logic [15:0] wc, act_first, act_end, frame_lines;
  logic [23:0] hdr;
  logic is_short, first_line, act_line, pix, take, last_line, line_end, frame_end;
  logic [7:0] pix_byte;

  // packet shape of the current segment
  always_comb begin
    act_first = 16'(cur_reg.vsa) + 16'(cur_reg.vbp);
    act_end = act_first + cur_reg.vact;
    frame_lines = act_end + 16'(cur_reg.vfp);
    first_line = (line_reg == 16'h0000);
    act_line = (line_reg >= act_first) && (line_reg < act_end);
    last_line = (line_reg == frame_lines - 16'h0001);
    is_short = (seg_reg == dsvs_pkg::SEG_SS) || (seg_reg == dsvs_pkg::SEG_SE) ||
               (seg_reg == dsvs_pkg::SEG_EOT);
    case (seg_reg)
      dsvs_pkg::SEG_SS: dt = first_line ? dsvs_pkg::DT_VSS : dsvs_pkg::DT_HSS;
      dsvs_pkg::SEG_SE: dt = first_line ? dsvs_pkg::DT_VSE : dsvs_pkg::DT_HSE;
      dsvs_pkg::SEG_EOT: dt = dsvs_pkg::DT_EOTP;
      dsvs_pkg::SEG_ACT: dt = act_line ? dsvs_pkg::DT_RGB888 : blank_dt_reg;
      default: dt = blank_dt_reg;
    endcase
    case (seg_reg)
      dsvs_pkg::SEG_SA: wc = cur_reg.hsa;
      dsvs_pkg::SEG_BP: wc = cur_reg.hbp;
      dsvs_pkg::SEG_ACT: wc = cur_reg.hact;
      dsvs_pkg::SEG_FP: wc = cur_reg.hfp;
      dsvs_pkg::SEG_EOT: wc = dsvs_pkg::EOTP_WORD;
      default: wc = dsvs_pkg::SHORT_WORD;
    endcase
    hdr = {wc[15:8], wc[7:0], dsvs_pkg::VC_ID, dt};
  end

  // pixel bytes are read straight off the beat, taken only in active payload
  always_comb begin
    pix = (st_reg == dsvs_pkg::ST_PAY) && (seg_reg == dsvs_pkg::SEG_ACT) && act_line;
    take = pix && ((beat_reg == BEAT_LAST) || (cnt_reg == wc - 16'h0001));
    pix_byte = s_axis_tvalid ? s_axis_tdata[beat_reg*8 +: 8] : dsvs_pkg::FILL_BYTE;
  end

  assign s_axis_tready = take;

  // next segment within the line, sync-pulse or sync-event order
  always_comb begin
    line_end = 1'b0;
    case (seg_reg)
      dsvs_pkg::SEG_SS: seg_adv = cur_reg.events_mode ? dsvs_pkg::SEG_BP : dsvs_pkg::SEG_SA;
      dsvs_pkg::SEG_SA: seg_adv = dsvs_pkg::SEG_SE;
      dsvs_pkg::SEG_SE: seg_adv = dsvs_pkg::SEG_BP;
      dsvs_pkg::SEG_BP: seg_adv = dsvs_pkg::SEG_ACT;
      dsvs_pkg::SEG_ACT: seg_adv = dsvs_pkg::SEG_FP;
      dsvs_pkg::SEG_FP: begin
        seg_adv = dsvs_pkg::SEG_SS;
        line_end = 1'b1;
      end
      default: begin
        seg_adv = dsvs_pkg::SEG_SS;
        line_end = 1'b1;
      end
    endcase
    frame_end = (seg_reg == dsvs_pkg::SEG_EOT) ||
                (line_end && last_line && !cur_reg.eotp);
  end

  // byte engine
  always_comb begin
    st_next = st_reg;
    seg_next = seg_reg;
    cnt_next = cnt_reg;
    line_next = line_reg;
    crc_next = crc_reg;
    lane_next = lane_reg;
    beat_next = beat_reg;
    cur_next = cur_reg;
    urun_tgl_next = urun_tgl_reg;
    frm_tgl_next = frm_tgl_reg;
    shadow_ok_next = shadow_ok_reg | cfg_bus.dst_load;
    // blanking type is frozen only while a header is on the wire
    blank_dt_next = (st_reg == dsvs_pkg::ST_HDR) ? blank_dt_reg :
                    (bn_s2_reg ? dsvs_pkg::DT_NULL : dsvs_pkg::DT_BLANK);
    byte_now = dsvs_pkg::FILL_BYTE;
    valid_next = (st_reg != dsvs_pkg::ST_IDLE);
    case (st_reg)
      dsvs_pkg::ST_IDLE: begin
        if (en_s2_reg && shadow_ok_reg) begin
          cur_next = shadow;
          line_next = 16'h0000;
          seg_next = dsvs_pkg::SEG_SS;
          cnt_next = 16'h0000;
          st_next = dsvs_pkg::ST_HDR;
        end
      end
      dsvs_pkg::ST_HDR: begin
        byte_now = (cnt_reg == HDR_LAST) ? dsvs_pkg::dsvs_ecc(hdr) : hdr[cnt_reg[1:0]*8 +: 8];
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == HDR_LAST) begin
          cnt_next = 16'h0000;
          crc_next = dsvs_pkg::CRC_INIT;
          beat_next = '0;
          if (!is_short) begin
            st_next = (wc == 16'h0000) ? dsvs_pkg::ST_CRC : dsvs_pkg::ST_PAY;
          end
        end
      end
      dsvs_pkg::ST_PAY: begin
        byte_now = pix ? pix_byte : dsvs_pkg::FILL_BYTE;
        crc_next = dsvs_pkg::dsvs_crc_byte(crc_reg, byte_now);
        beat_next = take ? '0 : beat_reg + 1'b1;
        if (take && !s_axis_tvalid) begin
          urun_tgl_next = ~urun_tgl_reg;
        end
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == wc - 16'h0001) begin
          cnt_next = 16'h0000;
          st_next = dsvs_pkg::ST_CRC;
        end
      end
      dsvs_pkg::ST_CRC: begin
        byte_now = !CRC_GEN ? dsvs_pkg::FILL_BYTE :
                   (cnt_reg == 16'h0000) ? crc_reg[7:0] : crc_reg[15:8];
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == CRC_LAST) begin
          cnt_next = 16'h0000;
        end
      end
      default: st_next = dsvs_pkg::ST_IDLE;
    endcase
    // packet done: short after header, long after checksum
    if (((st_reg == dsvs_pkg::ST_HDR) && (cnt_reg == HDR_LAST) && is_short) ||
        ((st_reg == dsvs_pkg::ST_CRC) && (cnt_reg == CRC_LAST))) begin
      st_next = dsvs_pkg::ST_HDR;
      seg_next = seg_adv;
      if (line_end && last_line && cur_reg.eotp && seg_reg != dsvs_pkg::SEG_EOT) begin
        seg_next = dsvs_pkg::SEG_EOT;
      end else if (line_end) begin
        line_next = line_reg + 16'h0001;
      end
      if (frame_end) begin
        frm_tgl_next = ~frm_tgl_reg;
        line_next = 16'h0000;
        seg_next = dsvs_pkg::SEG_SS;
        cur_next = shadow;
        if (!en_s2_reg) begin
          st_next = dsvs_pkg::ST_IDLE;
        end
      end
    end
    byte_next = byte_now;
    if (st_reg != dsvs_pkg::ST_IDLE) begin
      lane_next = (lane_reg == LANE_LAST) ? 2'h0 : lane_reg + 2'h1;
    end else begin
      lane_next = 2'h0;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      st_reg <= dsvs_pkg::ST_IDLE;
      seg_reg <= dsvs_pkg::SEG_SS;
      cnt_reg <= 16'h0000;
      line_reg <= 16'h0000;
      crc_reg <= dsvs_pkg::CRC_INIT;
      lane_reg <= 2'h0;
      beat_reg <= '0;
      cur_reg <= '0;
      shadow_ok_reg <= 1'b0;
      blank_dt_reg <= dsvs_pkg::DT_BLANK;
      byte_reg <= 8'h00;
      valid_reg <= 1'b0;
      urun_tgl_reg <= 1'b0;
      frm_tgl_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      seg_reg <= seg_next;
      cnt_reg <= cnt_next;
      line_reg <= line_next;
      crc_reg <= crc_next;
      lane_reg <= lane_next;
      beat_reg <= beat_next;
      cur_reg <= cur_next;
      shadow_ok_reg <= shadow_ok_next;
      blank_dt_reg <= blank_dt_next;
      byte_reg <= byte_next;
      valid_reg <= valid_next;
      urun_tgl_reg <= urun_tgl_next;
      frm_tgl_reg <= frm_tgl_next;
    end
  end

  // lane tag goes out with its byte; idle output shows lane 0, not the next lane
  logic [1:0] lane_out_reg, lane_out_next;
  assign lane_out_next = (st_reg != dsvs_pkg::ST_IDLE) ? lane_reg : 2'h0;
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      lane_out_reg <= 2'h0;
    end else begin
      lane_out_reg <= lane_out_next;
    end
  end

  assign link_byte = byte_reg;
  assign link_valid = valid_reg;
  assign link_lane = lane_out_reg;

  // ----------------------------------------
  // status back in the register domain
  // ----------------------------------------
  logic idle_s1_reg, idle_s2_reg;
  logic ur_s1_reg, ur_s2_reg, ur_s3_reg;
  logic fr_s1_reg, fr_s2_reg, fr_s3_reg;
  logic [dsvs_pkg::ISR_W-1:0] isr_reg, isr_next, isr_set;
  logic link_idle;

  // idle only once the last byte has left the output register; single flop into the sync
  assign link_idle = !valid_reg;

  // sticky status: a new event outweighs a clear in the same cycle
  always_comb begin
    isr_set = '0;
    isr_set[dsvs_pkg::ISR_UNDERRUN] = ur_s2_reg ^ ur_s3_reg;
    isr_set[dsvs_pkg::ISR_FRAME] = fr_s2_reg ^ fr_s3_reg;
    isr_next = soft_reset ? '0 : (isr_reg & ~isr_clear);
    isr_next = isr_next | isr_set;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idle_s1_reg <= 1'b1;
      idle_s2_reg <= 1'b1;
      ur_s1_reg <= 1'b0;
      ur_s2_reg <= 1'b0;
      ur_s3_reg <= 1'b0;
      fr_s1_reg <= 1'b0;
      fr_s2_reg <= 1'b0;
      fr_s3_reg <= 1'b0;
      isr_reg <= '0;
    end else begin
      idle_s1_reg <= link_idle;
      idle_s2_reg <= idle_s1_reg;
      ur_s1_reg <= urun_tgl_reg;
      ur_s2_reg <= ur_s1_reg;
      ur_s3_reg <= ur_s2_reg;
      fr_s1_reg <= frm_tgl_reg;
      fr_s2_reg <= fr_s1_reg;
      fr_s3_reg <= fr_s2_reg;
      isr_reg <= isr_next;
    end
  end

  // ready only once the framer has stopped and enable is low
  assign core_ready = idle_s2_reg && !core_enable;
  assign interrupt_status_reg = isr_reg;
  assign irq = irq_enable && |(isr_reg & irq_mask);

endmodule

// File: verif/dsvs_checker.sv
// port assertions of the video sequencer
`timescale 1ns/1ps
module dsvs_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic core_enable,
  input wire logic irq_enable,
  input wire logic [1:0] irq_mask,
  input wire logic soft_reset,
  input wire logic [1:0] isr_clear,
  input wire logic core_ready,
  input wire logic [1:0] interrupt_status_reg,
  input wire logic irq,
  input wire logic ctrl_rst_n,
  input wire logic phy_core_rst,
  input wire logic s_axis_tready,
  input wire logic [7:0] link_byte,
  input wire logic link_valid,
  input wire logic [1:0] link_lane
);
  // ----------------------------------------
  // register clock
  // ----------------------------------------
  a_rst_split: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl_rst_n && !phy_core_rst) else $error("reset outputs wrong");
  a_ready_low_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_enable |-> !core_ready) else $error("ready while enabled");
  a_ready_after_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(core_enable) |-> ##[1:1000] core_ready) else $error("ready never rose");
  a_ready_link_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_ready |-> !link_valid && !s_axis_tready) else $error("link busy when ready");
  a_irq_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq == (irq_enable && (interrupt_status_reg & irq_mask) != 2'h0))
    else $error("irq wrong");
  a_status_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !soft_reset && isr_clear == 2'h0 |=> &(interrupt_status_reg | ~$past(interrupt_status_reg)))
    else $error("status bit lost");
  // ----------------------------------------
  // link clock
  // ----------------------------------------
  sequence vss_hdr;
    link_byte == dsvs_pkg::DT_VSS ##1 link_byte == 8'h00 ##1 link_byte == 8'h00;
  endsequence
  a_frame_opens: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(link_valid) |-> vss_hdr) else $error("frame start header wrong");
  a_lane_step: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_valid && $past(link_valid) |-> link_lane == $past(link_lane) + 2'h1)
    else $error("lane order wrong");
  a_lane_idle: assert property (@(posedge link_clk) disable iff (sys_rst)
    !link_valid |-> link_lane == 2'h0) else $error("idle lane not zero");
  a_beat_take: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_axis_tready |-> link_valid ##1 !s_axis_tready [*2]) else $error("beat take wrong");
endmodule

bind dsvs_sequencer dsvs_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .link_clk(link_clk), .core_enable(core_enable), .irq_enable(irq_enable), .irq_mask(irq_mask),
  .soft_reset(soft_reset), .isr_clear(isr_clear), .core_ready(core_ready),
  .interrupt_status_reg(interrupt_status_reg), .irq(irq), .ctrl_rst_n(ctrl_rst_n),
  .phy_core_rst(phy_core_rst), .s_axis_tready(s_axis_tready), .link_byte(link_byte),
  .link_valid(link_valid), .link_lane(link_lane));

// File: verif/dsvs_panel_model.sv
// display end of the link: gathers bytes and checks lane order
`timescale 1ns/1ps
module dsvs_panel_model (
  input wire logic link_clk,
  input wire logic [7:0] link_byte,
  input wire logic link_valid,
  input wire logic [1:0] link_lane,
  output int lane_errs
);
  logic [7:0] rx_q[$];
  logic [1:0] lane_exp = 2'h0;
  // keep every valid byte; lanes take bytes in turn from 0
  always @(posedge link_clk) begin
    if (link_valid) begin
      rx_q.push_back(link_byte);
      if (link_lane !== lane_exp) lane_errs <= lane_errs + 1;
      lane_exp <= lane_exp + 2'h1;
    end else begin
      lane_exp <= 2'h0;
    end
  end
  initial lane_errs = 0;
endmodule

// File: verif/dsvs_sequencer_tb.sv
// testbench of the video sequencer
`timescale 1ns/1ps
module dsvs_sequencer_tb;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_enable = 1'b0;
  logic events_mode = 1'b0;
  logic blank_null = 1'b0;
  logic [15:0] wc = 16'h0003;
  logic soft_reset = 1'b0;
  logic [1:0] isr_clear = 2'h0;
  logic [1:0] irq_mask = 2'h3;
  logic irq_enable = 1'b0;
  logic src_on = 1'b0;
  logic s_axis_tvalid = 1'b0;
  logic [23:0] s_axis_tdata = 24'h332211;
  logic core_ready, irq, ctrl_rst_n, phy_core_rst, s_axis_tready, link_valid;
  logic [1:0] interrupt_status_reg, link_lane;
  logic [7:0] link_byte;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int lane_errs;

  dsvs_sequencer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk),
    .core_enable(core_enable), .events_mode(events_mode), .eotp_enable(1'b1),
    .blank_null(blank_null), .hsa_wc(wc), .hbp_wc(wc), .hact_wc(wc), .hfp_wc(wc),
    .vact_lines(16'h0001), .vsa_lines(8'h01), .vbp_lines(8'h00), .vfp_lines(8'h01),
    .soft_reset(soft_reset), .isr_clear(isr_clear), .irq_mask(irq_mask),
    .irq_enable(irq_enable), .core_ready(core_ready), .irq(irq),
    .interrupt_status_reg(interrupt_status_reg), .ctrl_rst_n(ctrl_rst_n),
    .phy_core_rst(phy_core_rst), .s_axis_tdata(s_axis_tdata), .s_axis_tvalid(s_axis_tvalid),
    .s_axis_tready(s_axis_tready), .link_byte(link_byte), .link_valid(link_valid),
    .link_lane(link_lane));
  dsvs_panel_model pm (.link_clk(link_clk), .link_byte(link_byte), .link_valid(link_valid),
    .link_lane(link_lane), .lane_errs(lane_errs));

  // ----------------------------------------
  // clocks, source and watchdog
  // ----------------------------------------
  // register clock
  always #2 clk_sys = ~clk_sys;
  // link clock, its rising edges never meet those of the register clock
  always #3 link_clk = ~link_clk;
  // pixel source keeps the stream valid unless starved on purpose
  always @(negedge link_clk) s_axis_tvalid <= src_on;
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 1000 && core_ready !== 1'b1; i++) @(negedge clk_sys);
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 3000 && pm.rx_q.size() < n; i++) @(negedge clk_sys);
  endtask
  // walk packet headers: types, counts and pixel bytes
  task automatic frame_check(input logic [151:0] di, input int n);
    int p;
    logic [7:0] d;
    p = 0;
    for (int i = n - 1; i >= 0; i--) begin
      d = pm.rx_q[p];
      check(d, di[8*i +: 8]);
      if (d == 8'h08 || d[3:0] == 4'h1) begin
        check({pm.rx_q[p+2], pm.rx_q[p+1]}, d == 8'h08 ? 16'h0f0f : 16'h0000);
        p = p + 4;
      end else begin
        check({pm.rx_q[p+2], pm.rx_q[p+1]}, wc);
        if (d == 8'h3e) check({pm.rx_q[p+6], pm.rx_q[p+5], pm.rx_q[p+4]}, s_axis_tdata);
        p = p + 6 + wc;
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({link_valid, s_axis_tready, irq, interrupt_status_reg}, 5'h00);
    check({ctrl_rst_n, phy_core_rst}, 2'h1);
    check(core_ready, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_pulse();
    src_on = 1'b1;
    wait_ready();
    core_enable = 1'b1; // controller first, the phy has no port here
    wait_bytes(136);
    frame_check({8'h01, 8'h19, 8'h11, 8'h19, 8'h19, 8'h19, 8'h21, 8'h19, 8'h31, 8'h19,
      8'h3e, 8'h19, 8'h21, 8'h19, 8'h31, 8'h19, 8'h19, 8'h19, 8'h08}, 19);
    check(lane_errs, 0);
    $display("t_pulse done");
  endtask
  task automatic t_events();
    int n;
    core_enable = 1'b0;
    events_mode = 1'b1;
    blank_null = 1'b1;
    wait_ready();
    check(core_ready, 1'b1);
    n = pm.rx_q.size();
    repeat (50) @(negedge clk_sys);
    check(pm.rx_q.size(), n);
    pm.rx_q.delete();
    core_enable = 1'b1;
    wait_bytes(97);
    frame_check({8'h01, 8'h09, 8'h09, 8'h09, 8'h21, 8'h09, 8'h3e, 8'h09, 8'h21, 8'h09,
      8'h09, 8'h09, 8'h08}, 13);
    $display("t_events done");
  endtask
  task automatic t_status();
    src_on = 1'b0;
    repeat (400) @(negedge clk_sys);
    check(interrupt_status_reg, 2'h3);
    check(irq, 1'b0);
    irq_enable = 1'b1;
    @(negedge clk_sys);
    check(irq, 1'b1);
    src_on = 1'b1;
    repeat (10) @(negedge clk_sys);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({interrupt_status_reg[0], link_valid}, 2'h1);
    // let a frame end set the bit again so that the clear has something to clear
    for (int i = 0; i < 300 && interrupt_status_reg[1] !== 1'b1; i++) @(negedge clk_sys);
    check(interrupt_status_reg[1], 1'b1);
    isr_clear = 2'h2;
    @(negedge clk_sys);
    isr_clear = 2'h0;
    repeat (2) @(negedge clk_sys);
    check(interrupt_status_reg[1], 1'b0);
    $display("t_status done");
  endtask

  // main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    t_reset();
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0; // reaches every flop of this block in time
    t_pulse();
    t_events();
    t_status();
    tally_and_finish();
  end
endmodule
